/* src/ccv_top.v */
// Clock calendar value registers with per-minute drift trim, as an APB slave.
// Assumes a single clock CLK_I at 100 MHz, one timer pulse per clock cycle,
// and an APB master that holds each request until PREADY is seen high.
//
// Behaviour
// - Weekday/hours time value holds weekday in bits 10-8, hour tens in 5-4 and hour units in 3-0, other bits zero.
// - Minutes/seconds time value holds minute tens 14-12, minute units 11-8, second tens 6-4, second units 3-0, bits 15 and 7 zero.
// - Alarm month/day holds month tens bit 12, month units 11-8, day tens 5-4 and day units 3-0, other bits zero.
// - Alarm weekday/hours uses the same layout as the weekday/hours time value.
// - Alarm minutes/seconds uses the same layout as the minutes/seconds time value.
// - Writes to weekday/hours time, alarm month/day and alarm weekday/hours are ignored unless write enable is one.
// - Once per minute the signed 8-bit trim times four is applied to the timer count.
// - A negative trim removes pulses each minute and a positive trim adds them.
// - Time value registers accept writes only while write enable is one.
// - The window pointer picks the time register pair and decrements on each upper-half access, stopping at zero.
// - Trim spans adding 508 pulses per minute to removing 512, with zero meaning no change.
// - The read-only half-second status clears on any write of the seconds half of minutes/seconds.
`include "ccv_defines.vh"
`timescale 1ns/100ps

module ccv_top #(
  parameter SEC_CYCLES = `CCV_SECOND_CYCLES
) (
  input wire CLK_I,
  input wire RST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [3:0] PSTRB_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  output reg SECOND_PULSE_O
);

  // ****************************************************************
  // Control state
  // ****************************************************************
  reg [7:0] trim;
  reg timer_en;
  reg wren;
  reg [1:0] ptr;
  reg half_sec;
  reg signed [32:0] presc;
  reg [3:0] sec_u;
  reg [2:0] sec_t;
  reg [3:0] min_u;
  reg [2:0] min_t;
  reg [3:0] hr_u;
  reg [1:0] hr_t;
  reg [2:0] weekday_digit;
  reg [15:0] alm_mthdy;
  reg [15:0] alm_wdhr;
  reg [15:0] alm_minutes_seconds_value;

  localparam [32:0] SEC_LAST = SEC_CYCLES - 1;
  localparam [32:0] SEC_HALF = SEC_CYCLES / 2;
  wire signed [32:0] sec_last = SEC_LAST;
  wire signed [32:0] sec_half = SEC_HALF;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire setup_done = PSEL_I & PENABLE_I & ~PREADY_O;
  wire access_end = PSEL_I & PENABLE_I & PREADY_O;
  wire wr = access_end & PWRITE_I;
  wire rd = access_end & ~PWRITE_I;
  wire hit_cfg = (PADDR_I == `CCV_OFS_CONFIG);
  wire hit_win = (PADDR_I == `CCV_OFS_WINDOW);
  wire hit_amd = (PADDR_I == `CCV_OFS_ALM_MTHDY);
  wire hit_awh = (PADDR_I == `CCV_OFS_ALM_WDHR);
  wire hit_ams = (PADDR_I == `CCV_OFS_ALM_MINUTES_SECONDS_VALUE);
  wire mapped = hit_cfg | hit_win | hit_amd | hit_awh | hit_ams;

  wire win_wr = wr & hit_win & wren;
  wire win_ms = (ptr == `CCV_PTR_MINUTES_SECONDS_VALUE);
  wire win_wh = (ptr == `CCV_PTR_WDHR);
  wire wr_sec = win_wr & win_ms & PSTRB_I[0];
  wire wr_min = win_wr & win_ms & PSTRB_I[1];
  wire wr_hr = win_wr & win_wh & PSTRB_I[0];
  wire wr_weekday_digit = win_wr & win_wh & PSTRB_I[1];
  // The seconds half clears the status even while locked, as it is a write attempt.
  wire clr_half = wr & hit_win & win_ms & PSTRB_I[0];
  wire upper_touch = (rd & hit_win) | (wr & hit_win & PSTRB_I[1]);

  // ****************************************************************
  // Time base and trim
  // ****************************************************************
  wire tick = timer_en & (presc >= sec_last);
  wire half_point = timer_en & (presc == sec_half);
  wire sec_wrap = (sec_u == 4'h9) & (sec_t == 3'h5);
  wire min_wrap = (min_u == 4'h9) & (min_t == 3'h5);
  wire hr_wrap = (hr_t == 2'h2) & (hr_u == 4'h3);
  // Loading the count ahead shortens the minute's first second and so adds pulses;
  // loading it below zero stretches that second and removes them.
  wire signed [32:0] trim_load = {{23{trim[7]}}, trim, 2'b00};

  always @(posedge CLK_I) begin
    if (RST_I) begin
      presc <= 33'sh0;
    end else if (tick) begin
      presc <= sec_wrap ? trim_load : 33'sh0;
    end else if (timer_en) begin
      presc <= presc + 33'sh1;
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      SECOND_PULSE_O <= 1'b0;
    end else begin
      SECOND_PULSE_O <= tick;
    end
  end

  // Hardware setting at the half point wins over a software clear.
  always @(posedge CLK_I) begin
    if (RST_I) begin
      half_sec <= 1'b0;
    end else if (half_point) begin
      half_sec <= 1'b1;
    end else if (tick | clr_half) begin
      half_sec <= 1'b0;
    end
  end

  // ****************************************************************
  // Time value counters
  // ****************************************************************
  // A software write in the same cycle as a tick wins, so a set time is exact.
  always @(posedge CLK_I) begin
    if (RST_I) begin
      sec_u <= `CCV_RST_DIGIT;
      sec_t <= 3'h0;
    end else if (wr_sec) begin
      sec_u <= PWDATA_I[3:0];
      sec_t <= PWDATA_I[6:4];
    end else if (tick) begin
      if (sec_u == 4'h9) begin
        sec_u <= 4'h0;
        sec_t <= (sec_t == 3'h5) ? 3'h0 : sec_t + 3'h1;
      end else begin
        sec_u <= sec_u + 4'h1;
      end
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      min_u <= `CCV_RST_DIGIT;
      min_t <= 3'h0;
    end else if (wr_min) begin
      min_u <= PWDATA_I[11:8];
      min_t <= PWDATA_I[14:12];
    end else if (tick & sec_wrap) begin
      if (min_u == 4'h9) begin
        min_u <= 4'h0;
        min_t <= (min_t == 3'h5) ? 3'h0 : min_t + 3'h1;
      end else begin
        min_u <= min_u + 4'h1;
      end
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      hr_u <= `CCV_RST_DIGIT;
      hr_t <= 2'h0;
    end else if (wr_hr) begin
      hr_u <= PWDATA_I[3:0];
      hr_t <= PWDATA_I[5:4];
    end else if (tick & sec_wrap & min_wrap) begin
      if (hr_wrap) begin
        hr_u <= 4'h0;
        hr_t <= 2'h0;
      end else if (hr_u == 4'h9) begin
        hr_u <= 4'h0;
        hr_t <= hr_t + 2'h1;
      end else begin
        hr_u <= hr_u + 4'h1;
      end
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      weekday_digit <= 3'h0;
    end else if (wr_weekday_digit) begin
      weekday_digit <= PWDATA_I[10:8];
    end else if (tick & sec_wrap & min_wrap & hr_wrap) begin
      weekday_digit <= (weekday_digit == 3'h6) ? 3'h0 : weekday_digit + 3'h1;
    end
  end

  // ****************************************************************
  // Configuration and alarm value registers
  // ****************************************************************
  always @(posedge CLK_I) begin
    if (RST_I) begin
      trim <= `CCV_RST_TRIM;
      timer_en <= 1'b0;
      wren <= 1'b0;
      ptr <= `CCV_RST_PTR;
    end else begin
      if (wr & hit_cfg & PSTRB_I[0]) begin
        trim <= PWDATA_I[`CCV_CFG_TRIM_HI:0];
      end
      if (wr & hit_cfg & PSTRB_I[1]) begin
        wren <= PWDATA_I[`CCV_CFG_WREN];
        // The timer enable only moves while writes are unlocked.
        if (wren) begin
          timer_en <= PWDATA_I[`CCV_CFG_TIMER_EN];
        end
        ptr <= PWDATA_I[`CCV_CFG_PTR_LO+1:`CCV_CFG_PTR_LO];
      end else if (upper_touch && ptr != 2'h0) begin
        ptr <= ptr - 2'h1;
      end
    end
  end

  // Byte strobes pick which half of an alarm value a write replaces.
  wire [15:0] amd_new = {PSTRB_I[1] ? PWDATA_I[15:8] : alm_mthdy[15:8],
    PSTRB_I[0] ? PWDATA_I[7:0] : alm_mthdy[7:0]};
  wire [15:0] awh_new = {PSTRB_I[1] ? PWDATA_I[15:8] : alm_wdhr[15:8],
    PSTRB_I[0] ? PWDATA_I[7:0] : alm_wdhr[7:0]};
  wire [15:0] ams_new = {PSTRB_I[1] ? PWDATA_I[15:8] : alm_minutes_seconds_value[15:8],
    PSTRB_I[0] ? PWDATA_I[7:0] : alm_minutes_seconds_value[7:0]};

  always @(posedge CLK_I) begin
    if (RST_I) begin
      alm_mthdy <= 16'h0000;
      alm_wdhr <= 16'h0000;
      alm_minutes_seconds_value <= 16'h0000;
    end else begin
      if (wr & hit_amd & wren) begin
        alm_mthdy <= amd_new & 16'h1f3f;
      end
      if (wr & hit_awh & wren) begin
        alm_wdhr <= awh_new & 16'h073f;
      end
      if (wr & hit_ams) begin
        alm_minutes_seconds_value <= ams_new & 16'h7f7f;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  reg [15:0] next_rdata;
  always @* begin
    next_rdata = 16'h0000;
    if (hit_cfg) begin
      next_rdata = {timer_en, 1'b0, wren, 1'b0, half_sec, 1'b0, ptr, trim};
    end else if (hit_win) begin
      if (win_ms) begin
        next_rdata = {1'b0, min_t, min_u, 1'b0, sec_t, sec_u};
      end else if (win_wh) begin
        next_rdata = {5'h00, weekday_digit, 2'h0, hr_t, hr_u};
      end
    end else if (hit_amd) begin
      next_rdata = alm_mthdy;
    end else if (hit_awh) begin
      next_rdata = alm_wdhr;
    end else if (hit_ams) begin
      next_rdata = alm_minutes_seconds_value;
    end
  end

  // One wait state: data is latched on the first access cycle, the transfer
  // completes on the second.
  always @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else if (setup_done) begin
      PREADY_O <= 1'b1;
      PRDATA_O <= PWRITE_I ? 32'h00000000 : {16'h0000, next_rdata};
      PSLVERR_O <= ~mapped;
    end else begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

endmodule

/* src/ccv_defines.vh */
// Constants for the clock calendar value and trim block: register offsets,
// field positions, reset values and timing counts.
// Assumes it is included by bare name from the design file.
`ifndef CCV_DEFINES_VH
`define CCV_DEFINES_VH

// Byte offsets on the register bus.
`define CCV_OFS_CONFIG 12'h000
`define CCV_OFS_WINDOW 12'h004
`define CCV_OFS_ALM_MTHDY 12'h008
`define CCV_OFS_ALM_WDHR 12'h00c
`define CCV_OFS_ALM_MINUTES_SECONDS_VALUE 12'h010

// Configuration register fields.
`define CCV_CFG_TRIM_HI 7
`define CCV_CFG_PTR_LO 8
`define CCV_CFG_HALF_SEC 11
`define CCV_CFG_WREN 13
`define CCV_CFG_TIMER_EN 15

// Window pointer codes.
`define CCV_PTR_MINUTES_SECONDS_VALUE 2'h0
`define CCV_PTR_WDHR 2'h1

// Reset values.
`define CCV_RST_TRIM 8'h00
`define CCV_RST_PTR 2'h0
`define CCV_RST_DIGIT 4'h0

// Timing: one second of time-keeping and the clock period.
`define CCV_SECOND_NS 1000000000
`define CCV_CLK_PERIOD_NS 10
`define CCV_SECOND_CYCLES (`CCV_SECOND_NS / `CCV_CLK_PERIOD_NS)

`endif

/* verif/ccv_monitor.sv */
// Checker for ccv_top: register read-back against shadow copies, seconds pulse.
// Assumes an APB master that holds each request until PREADY_O is high.
`timescale 1ns/100ps
module ccv_monitor #(parameter SEC_CYCLES = 100000000) (
  input wire CLK_I,
  input wire RST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [3:0] PSTRB_I,
  input wire [31:0] PRDATA_O,
  input wire PREADY_O,
  input wire PSLVERR_O,
  input wire SECOND_PULSE_O
);
  wire rd = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I;
  wire wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  reg [15:0] md, wh, ms;
  reg [7:0] trim;
  reg [1:0] ptr;
  reg wren;
  reg [31:0] gap;
  function [15:0] mrg(input [15:0] o, input [15:0] m);
    mrg = {PSTRB_I[1] ? PWDATA_I[15:8] : o[15:8], PSTRB_I[0] ? PWDATA_I[7:0] : o[7:0]} & m;
  endfunction
  always @(posedge CLK_I) begin
    if (RST_I) begin
      {md, wh, ms, trim, ptr, wren} <= 59'h0;
      gap <= 32'h0;
    end else begin
      gap <= SECOND_PULSE_O ? 32'h1 : gap + 32'h1;
      if (wr && wren && PADDR_I == 12'h008)
        md <= mrg(md, 16'h1f3f);
      if (wr && wren && PADDR_I == 12'h00c)
        wh <= mrg(wh, 16'h073f);
      if (wr && PADDR_I == 12'h010)
        ms <= mrg(ms, 16'h7f7f);
      if (wr && PADDR_I == 12'h000) begin
        trim <= PSTRB_I[0] ? PWDATA_I[7:0] : trim;
        {wren, ptr} <= PSTRB_I[1] ? {PWDATA_I[13], PWDATA_I[9:8]} : {wren, ptr};
      end else if (PADDR_I == 12'h004 && ptr != 2'h0 && (rd || wr && PSTRB_I[1]))
        ptr <= ptr - 2'h1;
    end
  end
  // ****************************
  // Read-back and pulse checks
  // ****************************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  a_window_zero_bits: assert property (rd && PADDR_I == 12'h004 |->
    (PRDATA_O & ~(ptr == 2'h1 ? 32'h073f : 32'h7f7f)) == 32'h0) else $error("window bits");
  a_alarm_md_value: assert property (rd && PADDR_I == 12'h008 |->
    PRDATA_O == {16'h0, md}) else $error("alarm month/day");
  a_alarm_wh_value: assert property (rd && PADDR_I == 12'h00c |->
    PRDATA_O == {16'h0, wh}) else $error("alarm weekday/hours");
  a_alarm_ms_value: assert property (rd && PADDR_I == 12'h010 |->
    PRDATA_O == {16'h0, ms}) else $error("alarm min/sec");
  a_trim_wren_readback: assert property (rd && PADDR_I == 12'h000 |->
    PRDATA_O[7:0] == trim && PRDATA_O[13] == wren) else $error("trim or enable");
  a_window_ptr_readback: assert property (rd && PADDR_I == 12'h000 |->
    PRDATA_O[9:8] == ptr) else $error("window pointer");
  a_pulse_single: assert property (SECOND_PULSE_O |=> !SECOND_PULSE_O)
    else $error("seconds pulse too long");
  a_second_min_gap: assert property (SECOND_PULSE_O |-> gap >= SEC_CYCLES - 508)
    else $error("second too short");
endmodule
bind ccv_top ccv_monitor #(.SEC_CYCLES(SEC_CYCLES)) mon_u (.CLK_I(CLK_I), .RST_I(RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .SECOND_PULSE_O(SECOND_PULSE_O));

/* verif/test_clock_calendar_values_and_trim.sv */
// Bench for ccv_top: locking, window pointer, rollover, half-second and trim.
// Assumes ccv_monitor is bound to the design; a second is shortened to SEC cycles.
`timescale 1ns/100ps
module test_clock_calendar_values_and_trim;
  localparam int SEC = 600;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rdv;
  logic [3:0] pst = 4'h0;
  logic rdy, err, sp, erv;
  logic [31:0] msk [3] = '{32'h1f3f, 32'h073f, 32'h7f7f};
  logic [7:0] trims [3] = '{8'h7f, 8'h80, 8'h00};
  int miscompares = 0, compares = 0, seed = 93301, n;
  ccv_top #(.SEC_CYCLES(SEC)) dut_u (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PSTRB_I(pst), .PRDATA_O(prd),
    .PREADY_O(rdy), .PSLVERR_O(err), .SECOND_PULSE_O(sp));
  always #5 clk = ~clk;
  // ****************
  // Bus and checks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The request stands until PREADY_O is seen high, for at most 50 cycles, then it is dropped as a miscompare.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    {psel, pwr, pa, pwd, pst} <= {1'b1, w, a, d, s};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1 && ++k < 50);
    if (k >= 50)
      miscompares++;
    rdv = prd;
    erv = err;
    {psel, pen} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h3);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rdv, e);
    chk({31'h0, erv}, {31'h0, (a > 12'h010)});
  endtask
  task automatic pulse();
    n = 0;
    do @(posedge clk); while (sp !== 1'b1 && ++n < 2000);
    if (n >= 2000)
      miscompares++;
  endtask
  task automatic test_done();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
  initial begin
    logic [31:0] d;
    trims[2] = $random(seed);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(12'h000, 32'h0);
    rdc(12'h014, 32'h0);
    for (int ph = 0; ph < 2; ph++) begin
      if (ph == 1)
        wr(12'h000, 32'h2000);
      for (int k = 0; k < 3; k++) begin
        d = $random(seed);
        wr(12'h008 + 12'(4 * k), d);
        rdc(12'h008 + 12'(4 * k), (ph[0] | k[1]) ? d & msk[k] : 32'h0);
      end
    end
    wr(12'h000, 32'h2100);
    wr(12'h004, 32'h0623);
    wr(12'h004, 32'h5959);
    rdc(12'h000, 32'h2000);
    wr(12'h000, 32'h0100);
    wr(12'h004, 32'h0111);
    wr(12'h000, 32'h2100);
    rdc(12'h004, 32'h0623);
    rdc(12'h000, 32'h2000);
    rdc(12'h004, 32'h5959);
    wr(12'h000, 32'ha000);
    pulse();
    wr(12'h000, 32'ha100);
    rdc(12'h004, 32'h0000);
    rdc(12'h004, 32'h0000);
    pulse();
    repeat (SEC / 2 + 10) @(posedge clk);
    rdc(12'h000, 32'ha800);
    apb(1'b1, 12'h004, 32'h0005, 4'h1);
    rdc(12'h000, 32'ha000);
    foreach (trims[i]) begin
      pulse();
      wr(12'h000, {16'h0000, 8'ha0, trims[i]});
      wr(12'h004, 32'h0058);
      pulse();
      pulse();
      pulse();
      chk(n + 1, SEC - 4 * $signed(trims[i]));
    end
    test_done();
  end
endmodule
